// ==== logic/hif_pkg.sv ====
// package: register map, field positions, reset values and timing of hif
package hif_pkg;
	// apb register byte offsets
	localparam logic [7:0] OFS_IRQ_MAIN = 8'h00;
	localparam logic [7:0] OFS_IRQ_TMR = 8'h04;
	localparam logic [7:0] OFS_IRQ_ERR = 8'h08;
	localparam logic [7:0] OFS_IRQ_PT = 8'h0c;
	localparam logic [7:0] OFS_MASK_MAIN = 8'h10;
	localparam logic [7:0] OFS_MASK_TMR = 8'h14;
	localparam logic [7:0] OFS_MASK_ERR = 8'h18;
	localparam logic [7:0] OFS_MASK_PT = 8'h1c;
	localparam logic [7:0] OFS_CMD = 8'h20;
	localparam logic [7:0] OFS_FIFO_DATA = 8'h24;
	localparam logic [7:0] OFS_FIFO_STAT = 8'h28;
	localparam logic [7:0] OFS_CLK_CFG = 8'h2c;
	// command codes written to OFS_CMD
	localparam logic [1:0] CMD_SET_DEFAULT = 2'h1;
	localparam logic [1:0] CMD_STOP_ALL = 2'h2;
	localparam logic [1:0] CMD_CLEAR_FIFO = 2'h3;
	// fifo status fields
	localparam int FST_OVF_BIT = 16;
	localparam int FST_UNF_BIT = 17;
	// clock config fields
	localparam int CLK_SEL_LSB = 0;
	localparam int CLK_LF_OFF_BIT = 2;
	// clock selector encodings
	localparam logic [1:0] CLK_SEL_OFF = 2'h0;
	localparam logic [1:0] CLK_SEL_DIV1 = 2'h1;
	localparam logic [1:0] CLK_SEL_DIV2 = 2'h2;
	localparam logic [1:0] CLK_SEL_DIV4 = 2'h3;
	localparam logic [1:0] CLK_SEL_RST = CLK_SEL_DIV4;
	localparam logic CLK_LF_OFF_RST = 1'b0;
	// fifo geometry
	localparam int FIFO_DEPTH = 512;
	localparam int FIFO_AW = 9;
	// low-frequency clock: 32 khz derived from the 25 mhz system clock
	localparam int SYS_CLK_HZ = 25000000;
	localparam int LF_CLK_HZ = 32000;
	localparam int LF_HALF_CYC = SYS_CLK_HZ / (2 * LF_CLK_HZ);
endpackage

// ==== logic/hif_fifo_mem.sv ====
// file: byte memory of the 512-byte data fifo, registered read
`timescale 1ns/1ps
`default_nettype none
module hif_fifo_mem #(
	parameter int AW = 9,
	parameter int DW = 8
) (
	// clock
	input wire logic clock_i,
	// write port
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	// read port
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clock_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule
`default_nettype wire

// ==== logic/hif_top.sv ====
// file: host notification, fifo status and mcu clock select of the reader
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module hif_top #(
	parameter int NSRC = 8,
	parameter int LF_HALF = hif_pkg::LF_HALF_CYC
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// interrupt sources, one-cycle pulses, four groups
	input wire logic [NSRC-1:0] ev_main_i,
	input wire logic [NSRC-1:0] ev_tmr_i,
	input wire logic [NSRC-1:0] ev_err_i,
	input wire logic [NSRC-1:0] ev_pt_i,
	// framer side of fifo
	input wire logic rx_start_i,
	input wire logic rx_wr_i,
	input wire logic [7:0] rx_data_i,
	input wire logic tx_rd_i,
	output logic [7:0] tx_data_o,
	// carrier clock and oscillator state
	input wire logic carrier_i,
	input wire logic xtal_on_i,
	// outputs
	output logic irq_o,
	output logic mcu_clk_o
);
	// ****************************************
	// apb decode
	// ****************************************
	logic acc, wr, rd;
	assign acc = psel_i & penable_i;
	assign wr = acc & pwrite_i;
	assign rd = acc & ~pwrite_i;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	logic cmd_def, cmd_stop, cmd_clr;
	assign cmd_def = wr & hit(paddr_i, hif_pkg::OFS_CMD) &
		(pwdata_i[1:0] == hif_pkg::CMD_SET_DEFAULT);
	assign cmd_stop = wr & hit(paddr_i, hif_pkg::OFS_CMD) &
		(pwdata_i[1:0] == hif_pkg::CMD_STOP_ALL);
	assign cmd_clr = wr & hit(paddr_i, hif_pkg::OFS_CMD) &
		(pwdata_i[1:0] == hif_pkg::CMD_CLEAR_FIFO);
	logic irq_clr_all;
	assign irq_clr_all = cmd_def | cmd_stop | cmd_clr;

	// ****************************************
	// interrupt status and masks
	// ****************************************
	logic [NSRC-1:0] stat_ff [4];
	logic [NSRC-1:0] nxt_stat [4];
	logic [NSRC-1:0] mask_ff [4];
	logic [NSRC-1:0] nxt_mask [4];
	logic [NSRC-1:0] ev [4];
	logic [3:0] pend;
	assign ev[0] = ev_main_i;
	assign ev[1] = ev_tmr_i;
	assign ev[2] = ev_err_i;
	assign ev[3] = ev_pt_i;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_irq
			logic rd_hit, mw_hit;
			assign rd_hit = rd & hit(paddr_i, 8'(g * 4));
			assign mw_hit = wr & hit(paddr_i, 8'(16 + g * 4));
			always_comb begin
				nxt_stat[g] = stat_ff[g];
				// read or command clears, events win over the clear
				// clear only what the setup cycle captured, so an event
				// landing mid-transfer stays pending
				if (rd_hit) begin
					nxt_stat[g] = stat_ff[g] & ~prdata_o[NSRC-1:0];
				end
				if (irq_clr_all) begin
					nxt_stat[g] = '0;
				end
				nxt_stat[g] = nxt_stat[g] | ev[g];
				nxt_mask[g] = mw_hit ? pwdata_i[NSRC-1:0] : mask_ff[g];
				if (cmd_def) begin
					nxt_mask[g] = '0;
				end
			end
			always_ff @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					stat_ff[g] <= '0;
					mask_ff[g] <= '0;
				end else begin
					stat_ff[g] <= nxt_stat[g];
					mask_ff[g] <= nxt_mask[g];
				end
			end
			// line follows unmasked pending bits, so unmask re-raises it
			assign pend[g] = |(nxt_stat[g] & ~nxt_mask[g]);
		end
	endgenerate

	logic nxt_irq;
	assign nxt_irq = |pend;

	// ****************************************
	// data fifo
	// ****************************************
	logic [hif_pkg::FIFO_AW:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
	logic ovf_ff, nxt_ovf, unf_ff, nxt_unf;
	logic full, empty, host_fw, host_fr, fifo_rst;
	logic do_w, do_r, rd_empty_ff, nxt_rd_empty;
	logic [7:0] wdat;
	logic [hif_pkg::FIFO_AW-1:0] raddr;
	logic [7:0] mem_q;
	logic byp_ff, nxt_byp;
	logic [7:0] byp_dat_ff;
	assign empty = (wp_ff == rp_ff);
	assign full = (wp_ff[hif_pkg::FIFO_AW] != rp_ff[hif_pkg::FIFO_AW]) &&
		(wp_ff[hif_pkg::FIFO_AW-1:0] == rp_ff[hif_pkg::FIFO_AW-1:0]);
	assign host_fw = wr & hit(paddr_i, hif_pkg::OFS_FIFO_DATA);
	assign host_fr = rd & hit(paddr_i, hif_pkg::OFS_FIFO_DATA);
	assign fifo_rst = rx_start_i | cmd_def | cmd_clr;
	assign do_w = (host_fw | rx_wr_i) & ~full;
	assign do_r = (host_fr | tx_rd_i) & ~empty;
	assign wdat = rx_wr_i ? rx_data_i : pwdata_i[7:0];
	// read address looks ahead so the registered output holds the head byte
	assign raddr = do_r ? nxt_rp[hif_pkg::FIFO_AW-1:0] :
		rp_ff[hif_pkg::FIFO_AW-1:0];

	always_comb begin
		nxt_wp = do_w ? wp_ff + 1'b1 : wp_ff;
		nxt_rp = do_r ? rp_ff + 1'b1 : rp_ff;
		nxt_ovf = ovf_ff | ((host_fw | rx_wr_i) & full);
		nxt_unf = unf_ff | ((host_fr | tx_rd_i) & empty);
		if (fifo_rst) begin
			nxt_wp = '0;
			nxt_rp = '0;
			nxt_ovf = 1'b0;
			nxt_unf = 1'b0;
		end
		nxt_rd_empty = (nxt_wp == nxt_rp);
		// memory returns the old byte when written and read at one edge
		nxt_byp = do_w & (wp_ff[hif_pkg::FIFO_AW-1:0] ==
			(do_r ? nxt_rp[hif_pkg::FIFO_AW-1:0] :
			rp_ff[hif_pkg::FIFO_AW-1:0]));
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_ff <= '0;
			rp_ff <= '0;
			ovf_ff <= 1'b0;
			unf_ff <= 1'b0;
			rd_empty_ff <= 1'b1;
			byp_ff <= 1'b0;
			byp_dat_ff <= 8'h00;
		end else begin
			wp_ff <= nxt_wp;
			rp_ff <= nxt_rp;
			ovf_ff <= nxt_ovf;
			unf_ff <= nxt_unf;
			rd_empty_ff <= nxt_rd_empty;
			byp_ff <= nxt_byp;
			byp_dat_ff <= wdat;
		end
	end

	hif_fifo_mem #(
		.AW(hif_pkg::FIFO_AW),
		.DW(8)
	) u_mem (
		.clock_i(clock_i),
		.we_i(do_w),
		.waddr_i(wp_ff[hif_pkg::FIFO_AW-1:0]),
		.wdata_i(wdat),
		.raddr_i(raddr),
		.rdata_o(mem_q)
	);

	logic [7:0] head;
	assign head = rd_empty_ff ? 8'h00 : (byp_ff ? byp_dat_ff : mem_q);

	// ****************************************
	// mcu clock
	// ****************************************
	logic [1:0] csel_ff, nxt_csel;
	logic lfoff_ff, nxt_lfoff;
	logic [1:0] cdiv_ff, nxt_cdiv;
	logic car_d_ff;
	logic [15:0] lfcnt_ff, nxt_lfcnt;
	logic lf_ff, nxt_lf, mclk_ff, nxt_mclk;
	logic car_rise;
	assign car_rise = carrier_i & ~car_d_ff;

	always_comb begin
		nxt_csel = csel_ff;
		nxt_lfoff = lfoff_ff;
		if (wr & hit(paddr_i, hif_pkg::OFS_CLK_CFG)) begin
			nxt_csel = pwdata_i[hif_pkg::CLK_SEL_LSB +: 2];
			nxt_lfoff = pwdata_i[hif_pkg::CLK_LF_OFF_BIT];
		end
		if (cmd_def) begin
			nxt_csel = hif_pkg::CLK_SEL_RST;
			nxt_lfoff = hif_pkg::CLK_LF_OFF_RST;
		end
		nxt_cdiv = car_rise ? cdiv_ff + 1'b1 : cdiv_ff;
		if (lfcnt_ff == 16'(LF_HALF - 1)) begin
			nxt_lfcnt = '0;
			nxt_lf = ~lf_ff;
		end else begin
			nxt_lfcnt = lfcnt_ff + 1'b1;
			nxt_lf = lf_ff;
		end
		// carrier is sampled, so divided outputs follow at system rate
		if (xtal_on_i) begin
			case (csel_ff)
				hif_pkg::CLK_SEL_DIV1: nxt_mclk = carrier_i;
				hif_pkg::CLK_SEL_DIV2: nxt_mclk = cdiv_ff[0];
				hif_pkg::CLK_SEL_DIV4: nxt_mclk = cdiv_ff[1];
				default: nxt_mclk = 1'b0;
			endcase
		end else begin
			nxt_mclk = lf_ff & ~lfoff_ff;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			csel_ff <= hif_pkg::CLK_SEL_RST;
			lfoff_ff <= hif_pkg::CLK_LF_OFF_RST;
			cdiv_ff <= '0;
			car_d_ff <= 1'b0;
			lfcnt_ff <= '0;
			lf_ff <= 1'b0;
			mclk_ff <= 1'b0;
		end else begin
			csel_ff <= nxt_csel;
			lfoff_ff <= nxt_lfoff;
			cdiv_ff <= nxt_cdiv;
			car_d_ff <= carrier_i;
			lfcnt_ff <= nxt_lfcnt;
			lf_ff <= nxt_lf;
			mclk_ff <= nxt_mclk;
		end
	end

	// ****************************************
	// apb read data and outputs
	// ****************************************
	logic [31:0] nxt_prdata;
	always_comb begin
		nxt_prdata = '0;
		case (paddr_i)
			hif_pkg::OFS_IRQ_MAIN: nxt_prdata = 32'(stat_ff[0]);
			hif_pkg::OFS_IRQ_TMR: nxt_prdata = 32'(stat_ff[1]);
			hif_pkg::OFS_IRQ_ERR: nxt_prdata = 32'(stat_ff[2]);
			hif_pkg::OFS_IRQ_PT: nxt_prdata = 32'(stat_ff[3]);
			hif_pkg::OFS_MASK_MAIN: nxt_prdata = 32'(mask_ff[0]);
			hif_pkg::OFS_MASK_TMR: nxt_prdata = 32'(mask_ff[1]);
			hif_pkg::OFS_MASK_ERR: nxt_prdata = 32'(mask_ff[2]);
			hif_pkg::OFS_MASK_PT: nxt_prdata = 32'(mask_ff[3]);
			hif_pkg::OFS_FIFO_DATA: nxt_prdata = 32'(head);
			hif_pkg::OFS_FIFO_STAT: begin
				nxt_prdata[hif_pkg::FIFO_AW:0] = wp_ff - rp_ff;
				nxt_prdata[hif_pkg::FST_OVF_BIT] = ovf_ff;
				nxt_prdata[hif_pkg::FST_UNF_BIT] = unf_ff;
			end
			hif_pkg::OFS_CLK_CFG: begin
				nxt_prdata[hif_pkg::CLK_SEL_LSB +: 2] = csel_ff;
				nxt_prdata[hif_pkg::CLK_LF_OFF_BIT] = lfoff_ff;
			end
			default: nxt_prdata = '0;
		endcase
	end

	// answer in the first cycle of the access phase: no wait state
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o <= '0;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			irq_o <= 1'b0;
			tx_data_o <= 8'h00;
			mcu_clk_o <= 1'b0;
		end else begin
			prdata_o <= (psel_i & ~penable_i) ? nxt_prdata : prdata_o;
			pready_o <= psel_i & ~penable_i;
			pslverr_o <= 1'b0;
			irq_o <= nxt_irq;
			tx_data_o <= head;
			mcu_clk_o <= mclk_ff;
		end
	end
endmodule
`default_nettype wire

// ==== test/hif_top_properties.sv ====
// checker: apb, interrupt line and fifo relations seen at the hif ports
`timescale 1ns/1ps
`default_nettype none
module hif_top_properties #(
	parameter int NSRC = 8
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// events, framer, irq
	input wire logic [NSRC-1:0] ev_main_i,
	input wire logic [NSRC-1:0] ev_tmr_i,
	input wire logic [NSRC-1:0] ev_err_i,
	input wire logic [NSRC-1:0] ev_pt_i,
	input wire logic rx_start_i,
	input wire logic rx_wr_i,
	input wire logic [7:0] tx_data_o,
	input wire logic irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// two quiet cycles: the line rises at the same edge as the status bit
	wire acc_w = psel_i && penable_i;
	wire quiet_w = !(|{ev_main_i, ev_tmr_i, ev_err_i, ev_pt_i}) &&
		!(acc_w && pwrite_i);
	property p_ready; psel_i && !penable_i |=> pready_o; endproperty
	a_ready: assert property (p_ready) else $error("no pready");
	property p_ready_one; pready_o |=> !pready_o; endproperty
	a_ready_one: assert property (p_ready_one) else $error("long pready");
	property p_noerr; pready_o |-> !pslverr_o; endproperty
	a_noerr: assert property (p_noerr) else $error("pslverr set");
	property p_unmapped;
		psel_i && !penable_i && !pwrite_i && paddr_i > 8'h2c |=>
			prdata_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("bad rdata");
	property p_rdata_hold; !(psel_i && !penable_i) |=> $stable(prdata_o); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
	property p_irq_rise; (!irq_o && quiet_w) [*2] |=> !irq_o; endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq rose");
	property p_irq_hold; (irq_o && !acc_w) [*2] |=> irq_o; endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq fell");
	property p_fifo_zero;
		(rx_start_i && !rx_wr_i) ##1 (!rx_wr_i && !psel_i) [*2] |->
			tx_data_o == 8'h00;
	endproperty
	a_fifo_zero: assert property (p_fifo_zero) else $error("fifo data");
endmodule
bind hif_top hif_top_properties #(.NSRC(NSRC)) u_props (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.ev_main_i(ev_main_i), .ev_tmr_i(ev_tmr_i), .ev_err_i(ev_err_i),
	.ev_pt_i(ev_pt_i), .rx_start_i(rx_start_i), .rx_wr_i(rx_wr_i),
	.tx_data_o(tx_data_o), .irq_o(irq_o));
`default_nettype wire

// ==== test/hif_mcu_model.sv ====
// mcu model: apb master that starts every transfer and queues expected read data
`timescale 1ns/1ps
`default_nettype none
module hif_mcu_model (
	// clock
	input wire logic clock_i,
	// apb master
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [7:0] paddr_o,
	output logic [31:0] pwdata_o,
	input wire logic pready_i,
	// mcu clock and stuck flag
	input wire logic mcu_clk_i,
	output logic hang_o
);
	logic [31:0] exp_q [$];
	int mclk_edges = 0;
	initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o, hang_o} = '0;
	always @(posedge mcu_clk_i) mclk_edges++;
	// only this model starts transfers; a stuck slave ends the wait
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clock_i);
		penable_o <= 1'b1;
		@(posedge clock_i);
		while (pready_i !== 1'b1 && n < 16) begin
			@(posedge clock_i);
			n++;
		end
		if (pready_i !== 1'b1) hang_o <= 1'b1;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		pwdata_o <= ~d;
		@(posedge clock_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	// read queues the expected value, then runs the transfer; it does not wait for the irq line
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask
endmodule
`default_nettype wire

// ==== test/hif_top_tb.sv ====
// bench: drives hif through the mcu model, checks reads, irq and clock
`timescale 1ns/1ps
`default_nettype none
module hif_top_tb;
	logic clock_i = 0;
	logic rst_n_i = 0;
	logic psel, penable, pwrite, pready, pslverr, hang, irq, mclk;
	logic [7:0] paddr, tx_data;
	logic [31:0] pwdata, prdata;
	logic [7:0] ev [4];
	logic rx_start = 0, rx_wr = 0, tx_rd = 0, carrier = 0, xtal = 1;
	logic [7:0] rx_data = 8'h00;
	logic [7:0] bt [3];
	int n_fail = 0, cmp_count = 0, seed = 32'heb66eca3, b, e0;
	int ck [4] = '{0, 32, 16, 8};
	initial for (int i = 0; i < 4; i++) ev[i] = 8'h00;
	always #20 clock_i = ~clock_i;
	always @(posedge clock_i) carrier <= ~carrier;
	hif_top #(.LF_HALF(2)) u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .ev_main_i(ev[0]),
		.ev_tmr_i(ev[1]), .ev_err_i(ev[2]), .ev_pt_i(ev[3]),
		.rx_start_i(rx_start), .rx_wr_i(rx_wr), .rx_data_i(rx_data),
		.tx_rd_i(tx_rd), .tx_data_o(tx_data), .carrier_i(carrier),
		.xtal_on_i(xtal), .irq_o(irq), .mcu_clk_o(mclk));
	hif_mcu_model u_mcu (.clock_i(clock_i), .psel_o(psel),
		.penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
		.pwdata_o(pwdata), .pready_i(pready), .mcu_clk_i(mclk),
		.hang_o(hang));
	// ***************************************
	// helpers
	// ***************************************
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic wrap_up;
		if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task automatic irq_is(input logic v);
		cyc(1);
		chk("irq", irq, v);
	endtask
	task automatic pulse(input int g, input logic [7:0] v);
		ev[g] <= v;
		cyc(1);
		ev[g] <= 8'h00;
		cyc(1);
	endtask
	// divider needs a few cycles to settle after a change
	task automatic mclk_is(input int e);
		cyc(8);
		e0 = u_mcu.mclk_edges;
		cyc(64);
		chk("mclk", u_mcu.mclk_edges - e0, e);
	endtask
	always @(posedge hang) begin
		n_fail++;
		wrap_up();
	end
	always @(posedge clock_i)
		if (pready === 1'b1 && pwrite === 1'b0 && u_mcu.exp_q.size() > 0)
			chk("prdata", prdata, u_mcu.exp_q.pop_front());
	initial begin
		cyc(16);
		rst_n_i <= 1'b1;
		mclk_is(8);
		for (int s = 0; s < 4; s++) begin
			u_mcu.wr(hif_pkg::OFS_CLK_CFG, 32'(s));
			mclk_is(ck[s]);
		end
		xtal <= 1'b0;
		mclk_is(16);
		u_mcu.wr(hif_pkg::OFS_CLK_CFG, 32'h7);
		mclk_is(0);
		xtal <= 1'b1;
		u_mcu.rd(8'h3c, 32'h0);
		for (int g = 0; g < 4; g++) begin
			b = {$random(seed)} % 8;
			pulse(g, 8'h01 << b);
			irq_is(1'b1);
			u_mcu.rd(8'(4 * g), 32'h1 << b);
			irq_is(1'b0);
			u_mcu.rd(8'(4 * g), 32'h0);
		end
		pulse(0, 8'h81);
		pulse(1, 8'h02);
		u_mcu.rd(hif_pkg::OFS_IRQ_MAIN, 32'h81);
		irq_is(1'b1);
		u_mcu.rd(hif_pkg::OFS_IRQ_TMR, 32'h2);
		irq_is(1'b0);
		u_mcu.wr(hif_pkg::OFS_MASK_ERR, 32'hff);
		pulse(2, 8'h10);
		irq_is(1'b0);
		u_mcu.rd(hif_pkg::OFS_IRQ_ERR, 32'h10);
		pulse(2, 8'h04);
		u_mcu.wr(hif_pkg::OFS_MASK_ERR, 32'h0);
		irq_is(1'b1);
		u_mcu.rd(hif_pkg::OFS_IRQ_ERR, 32'h4);
		for (int c = 1; c < 4; c++) begin
			pulse(3, 8'h40);
			u_mcu.wr(hif_pkg::OFS_CMD, 32'(c));
			irq_is(1'b0);
			u_mcu.rd(hif_pkg::OFS_IRQ_PT, 32'h0);
		end
		for (int i = 0; i < 513; i++) u_mcu.wr(hif_pkg::OFS_FIFO_DATA, 32'(i));
		u_mcu.rd(hif_pkg::OFS_FIFO_STAT, 32'h10200);
		u_mcu.wr(hif_pkg::OFS_CMD, 32'(hif_pkg::CMD_CLEAR_FIFO));
		u_mcu.rd(hif_pkg::OFS_FIFO_STAT, 32'h0);
		u_mcu.rd(hif_pkg::OFS_FIFO_DATA, 32'h0);
		u_mcu.rd(hif_pkg::OFS_FIFO_STAT, 32'h20000);
		rx_start <= 1'b1;
		cyc(1);
		rx_start <= 1'b0;
		cyc(3);
		u_mcu.rd(hif_pkg::OFS_FIFO_STAT, 32'h0);
		for (int i = 0; i < 3; i++) begin
			bt[i] = 8'($random(seed));
			rx_data <= bt[i];
			rx_wr <= 1'b1;
			cyc(1);
			rx_wr <= 1'b0;
			cyc(1);
		end
		cyc(1);
		chk("tx_data", tx_data, bt[0]);
		tx_rd <= 1'b1;
		cyc(1);
		tx_rd <= 1'b0;
		cyc(2);
		chk("tx_data", tx_data, bt[1]);
		u_mcu.rd(hif_pkg::OFS_FIFO_DATA, {24'h0, bt[1]});
		u_mcu.rd(hif_pkg::OFS_FIFO_DATA, {24'h0, bt[2]});
		cyc(2);
		wrap_up();
	end
endmodule
`default_nettype wire
